// ### logic/ppcs_pkg.sv
// constants, types and shared enumerations of the PD class/startup sequencer
// assumes a single 25 MHz core clock and comparator inputs already digital
//
// Function
// - type 2 config presents class 4 always
// - class 5/6: class 4 twice, then 0/1
// - class 7/8: class 4 twice, then 2/3
// - grant needs 2/4/5 events, else demoted
// - one to five events, class from pins
// - class off above cutoff, thermal, adapter, detect
// - latch allocation decode after good classification
// - broken sequence waits for mark reset
// - inrush limit level per variant
// - keepalive pulses while return current low
// - type 1-2 pulse 75 ms every 325 ms
// - type 3-4 source: one-tenth pulse length
// - three selectable keepalive duty settings
// - keepalive stays active with adapter detect
// - switch on above rising lockout, return high
// - converter and bias off during inrush
// - operational limit after inrush current drops
// - converter go after inrush and 81.5 ms
// - bias switch on, startup off 24 ms later
// - code outputs enabled within code delay
// - 50 ms startup timeout, retry on undervolt
// - bias undervolt level selectable
// - falling lockout: switch off, converter go stays
// - adapter detect forces code low-high-high
// - detect enable low forces switch off
package ppcs_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned FILT_CYCLES = 4;
    localparam int unsigned INRUSH_MIN_US = 81_500;
    localparam int unsigned BIAS_HOLD_US = 24_000;
    localparam int unsigned STARTUP_TMO_US = 50_000;
    localparam int unsigned KA_T12_ON_US = 75_000;
    localparam int unsigned KA_T12_PER_US = 325_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned INRUSH_MIN_CYC = INRUSH_MIN_US * CYC_PER_US;
    localparam int unsigned BIAS_HOLD_CYC = BIAS_HOLD_US * CYC_PER_US;
    localparam int unsigned STARTUP_TMO_CYC = STARTUP_TMO_US * CYC_PER_US;
    localparam int unsigned KA_T12_ON_CYC = KA_T12_ON_US * CYC_PER_US;
    localparam int unsigned KA_T12_PER_CYC = KA_T12_PER_US * CYC_PER_US;
    localparam logic [2:0] CODE_ADAPTER = 3'h3;
    localparam logic [2:0] CODE_RESET = 3'h0;
    localparam logic [1:0] HW_CLASS4 = 2'h0;

    // class setting: 0 = class 4 (type 2), 1..2 = class 5/6, 3..4 = class 7/8
    typedef enum logic [2:0] {PPCS_C4, PPCS_C5, PPCS_C6, PPCS_C7, PPCS_C8} ppcs_class_t;

    typedef struct packed {
        logic above_mark_reset;
        logic in_class_range;
        logic in_mark_range;
        logic above_cutoff;
        logic lockout_rising;
        logic lockout_falling_ok;
        logic return_high;
        logic inrush_done;
        logic bias_in_on;
        logic bias_out_uv_hi;
        logic bias_out_uv_lo;
        logic return_low_current;
        logic high_type_source;
    } ppcs_cmp_t;

    typedef struct packed {
        logic class_en;
        logic [2:0] class_sel;
    } ppcs_class_drive_t;

    function automatic logic [2:0] ppcs_later_class(input ppcs_class_t c);
        unique case (c)
            PPCS_C5: ppcs_later_class = 3'h0;
            PPCS_C6: ppcs_later_class = 3'h1;
            PPCS_C7: ppcs_later_class = 3'h2;
            PPCS_C8: ppcs_later_class = 3'h3;
            default: ppcs_later_class = 3'h4;
        endcase
    endfunction

    function automatic logic [2:0] ppcs_needed_events(input ppcs_class_t c);
        unique case (c)
            PPCS_C5, PPCS_C6: ppcs_needed_events = 3'h4;
            PPCS_C7, PPCS_C8: ppcs_needed_events = 3'h5;
            default: ppcs_needed_events = 3'h2;
        endcase
    endfunction
endpackage

// ### logic/ppcs_filter.sv
// comparator synchroniser and glitch filter, one per comparator bit
// assumes inputs are raw comparator levels
`timescale 1ns/1ns
module ppcs_filter #(
    parameter int WIDTH = 13,
    parameter int CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] clean
);
    logic [WIDTH-1:0] s1_reg, s2_reg, clean_reg, clean_next;
    logic [WIDTH-1:0][3:0] cnt_reg, cnt_next;

    // ====================
    // filter
    always_comb begin
        clean_next = clean_reg;
        cnt_next = cnt_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == clean_reg[i]) begin
                cnt_next[i] = 4'h0;
            end else if (cnt_reg[i] == 4'(CYCLES - 1)) begin
                clean_next[i] = s2_reg[i];
                cnt_next[i] = 4'h0;
            end else begin
                cnt_next[i] = cnt_reg[i] + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        s1_reg <= raw;
        s2_reg <= s1_reg;
        if (rst) begin
            clean_reg <= '0;
            cnt_reg <= '0;
        end else begin
            clean_reg <= clean_next;
            cnt_reg <= cnt_next;
        end
    end

    assign clean = clean_reg;
endmodule

// ### logic/ppcs_keepalive.sv
// keepalive pulse generator for the maintain power signature
// assumes enable and source type are already filtered
`timescale 1ns/1ns
module ppcs_keepalive #(
    parameter int unsigned T12_ON = ppcs_pkg::KA_T12_ON_CYC,
    parameter int unsigned T12_PER = ppcs_pkg::KA_T12_PER_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic high_type,
    input wire logic [1:0] duty_sel,
    output logic pulse
);
    logic [23:0] cnt_reg, cnt_next;
    logic pulse_reg, pulse_next;
    logic [23:0] on_len, per_len;

    // ====================
    // length selection
    always_comb begin
        // longer settings cover long cables and large bulk caps
        unique case (duty_sel)
            2'h1: on_len = 24'(T12_ON + T12_ON / 2);
            2'h2: on_len = 24'(T12_ON * 2);
            default: on_len = 24'(T12_ON);
        endcase
        per_len = 24'(T12_PER);
        if (high_type) begin
            on_len = on_len / 24'hA;
            per_len = per_len / 24'hA;
        end
    end

    always_comb begin
        cnt_next = cnt_reg;
        pulse_next = 1'b0;
        if (enable) begin
            cnt_next = (cnt_reg >= per_len - 24'h1) ? 24'h0 : cnt_reg + 24'h1;
            pulse_next = cnt_next < on_len;
        end else begin
            cnt_next = 24'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= 24'h0;
            pulse_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse = pulse_reg;
endmodule

// ### logic/ppcs_sequencer.sv
// top of the PD classification and startup sequencer
// assumes analog thresholds arrive as comparator levels on core_clk
`timescale 1ns/1ns
module ppcs_sequencer #(
    parameter int unsigned INRUSH_MIN = ppcs_pkg::INRUSH_MIN_CYC,
    parameter int unsigned BIAS_HOLD = ppcs_pkg::BIAS_HOLD_CYC,
    parameter int unsigned STARTUP_TMO = ppcs_pkg::STARTUP_TMO_CYC,
    parameter int unsigned KA_ON = ppcs_pkg::KA_T12_ON_CYC,
    parameter int unsigned KA_PER = ppcs_pkg::KA_T12_PER_CYC,
    parameter bit HIGH_POWER_VARIANT = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire ppcs_pkg::ppcs_cmp_t cmp_raw,
    input wire ppcs_pkg::ppcs_class_t class_setting,
    input wire logic thermal_limit,
    input wire logic adapter_detect,
    input wire logic detect_enable,
    input wire logic [1:0] keepalive_duty_select,
    input wire logic bias_undervolt_select,
    output ppcs_pkg::ppcs_class_drive_t class_drive,
    output logic hotswap_on,
    output logic inrush_limit_high,
    output logic op_limit_high,
    output logic limit_operational,
    output logic converter_go_oe,
    output logic bias_switch_on,
    output logic startup_source_on,
    output logic keepalive_pulse_drive,
    output logic alloc_code_low,
    output logic alloc_code_high,
    output logic high_type_flag,
    output logic code_enable,
    output logic power_granted
);
    ppcs_pkg::ppcs_cmp_t cmp;
    logic ka_pulse;

    ppcs_filter #(.WIDTH($bits(ppcs_pkg::ppcs_cmp_t)), .CYCLES(ppcs_pkg::FILT_CYCLES)) u_filt (
        .core_clk(core_clk),
        .rst(rst),
        .raw(cmp_raw),
        .clean(cmp)
    );

    // ====================
    // classification
    typedef enum logic [2:0] {CL_IDLE, CL_CLASS, CL_MARK, CL_BROKEN, CL_POWERED} ppcs_cl_state_t;
    ppcs_cl_state_t cl_reg, cl_next;
    logic [2:0] events_reg, events_next;
    logic [2:0] code_reg, code_next;
    logic granted_reg, granted_next;
    logic class_en_next;
    logic [2:0] class_sel_next;
    ppcs_pkg::ppcs_class_drive_t drive_reg;

    always_comb begin
        cl_next = cl_reg;
        events_next = events_reg;
        code_next = code_reg;
        granted_next = granted_reg;
        class_en_next = 1'b0;
        class_sel_next = 3'h4;
        unique case (cl_reg)
            CL_IDLE: begin
                events_next = 3'h0;
                if (cmp.in_class_range) begin
                    cl_next = CL_CLASS;
                    events_next = 3'h1;
                end
            end
            CL_CLASS: begin
                // class 4 in the first two events, setting afterwards
                class_sel_next = (events_reg <= 3'h2) ? 3'h4 : ppcs_pkg::ppcs_later_class(class_setting);
                class_en_next = 1'b1;
                if (cmp.lockout_rising) begin
                    cl_next = CL_POWERED;
                end else if (cmp.in_mark_range) begin
                    cl_next = CL_MARK;
                end else if (!cmp.above_mark_reset) begin
                    cl_next = CL_BROKEN;
                end
            end
            CL_MARK: begin
                if (cmp.lockout_rising) begin
                    cl_next = CL_POWERED;
                end else if (cmp.in_class_range) begin
                    cl_next = CL_CLASS;
                    if (events_reg != 3'h5) begin
                        events_next = events_reg + 3'h1;
                    end
                end else if (!cmp.above_mark_reset) begin
                    cl_next = CL_IDLE;
                end
            end
            CL_BROKEN: begin
                if (!cmp.above_mark_reset) begin
                    cl_next = CL_IDLE;
                end
            end
            CL_POWERED: begin
                if (!cmp.above_mark_reset) begin
                    cl_next = CL_IDLE;
                end
            end
            default: cl_next = CL_IDLE;
        endcase
        if (cl_reg != CL_POWERED && cl_next == CL_POWERED) begin
            granted_next = events_reg >= ppcs_pkg::ppcs_needed_events(class_setting);
            // low bit: class 5+ granted, high bit: class 7+ granted, top bit: type 3-4 source
            code_next = {cmp.high_type_source, events_reg >= 3'h5, events_reg >= 3'h4};
        end
        if (cmp.above_cutoff || thermal_limit || adapter_detect || !detect_enable) begin
            class_en_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cl_reg <= CL_IDLE;
            events_reg <= 3'h0;
            code_reg <= ppcs_pkg::CODE_RESET;
            granted_reg <= 1'b0;
            drive_reg <= '0;
        end else begin
            cl_reg <= cl_next;
            events_reg <= events_next;
            code_reg <= code_next;
            granted_reg <= granted_next;
            drive_reg <= '{class_en: class_en_next, class_sel: class_sel_next};
        end
    end

    // ====================
    // hotswap and startup
    typedef enum logic [2:0] {SU_OFF, SU_INRUSH, SU_START, SU_HOLD, SU_RUN, SU_RETRY} ppcs_su_state_t;
    ppcs_su_state_t su_reg, su_next;
    logic [23:0] tmr_reg, tmr_next;
    logic sw_reg, sw_next, oplim_reg, oplim_next, go_reg, go_next;
    logic bsw_reg, bsw_next, src_reg, src_next, cen_reg, cen_next;
    logic force_off, bias_uv;

    assign force_off = !detect_enable || thermal_limit;
    assign bias_uv = bias_undervolt_select ? cmp.bias_out_uv_lo : cmp.bias_out_uv_hi;

    always_comb begin
        su_next = su_reg;
        tmr_next = (tmr_reg == 24'hFFFFFF) ? tmr_reg : tmr_reg + 24'h1;
        sw_next = sw_reg;
        oplim_next = oplim_reg;
        go_next = go_reg;
        bsw_next = bsw_reg;
        src_next = src_reg;
        cen_next = cen_reg;
        unique case (su_reg)
            SU_OFF: begin
                sw_next = 1'b0;
                oplim_next = 1'b0;
                if (cmp.lockout_rising && cmp.return_high && !force_off) begin
                    su_next = SU_INRUSH;
                    sw_next = 1'b1;
                    tmr_next = 24'h0;
                end
            end
            SU_INRUSH: begin
                go_next = 1'b0;
                bsw_next = 1'b0;
                src_next = 1'b0;
                if (cmp.inrush_done) begin
                    oplim_next = 1'b1;
                end
                if (oplim_reg && tmr_reg >= 24'(INRUSH_MIN)) begin
                    su_next = SU_START;
                    go_next = 1'b1;
                    src_next = 1'b1;
                    tmr_next = 24'h0;
                end
            end
            SU_START: begin
                if (cmp.bias_in_on) begin
                    su_next = SU_HOLD;
                    bsw_next = 1'b1;
                    tmr_next = 24'h0;
                end else if (tmr_reg >= 24'(STARTUP_TMO)) begin
                    su_next = SU_RETRY;
                    src_next = 1'b0;
                    bsw_next = 1'b1;
                end
            end
            SU_HOLD: begin
                // codes appear as soon as bias comes up, well inside the delay
                cen_next = 1'b1;
                if (tmr_reg >= 24'(BIAS_HOLD)) begin
                    su_next = SU_RUN;
                    src_next = 1'b0;
                end
            end
            SU_RUN: begin
            end
            SU_RETRY: begin
                if (bias_uv) begin
                    su_next = SU_START;
                    bsw_next = 1'b0;
                    src_next = 1'b1;
                    tmr_next = 24'h0;
                end
            end
            default: su_next = SU_OFF;
        endcase
        // converter go is left released; downstream runs on until its own lockout
        if (su_reg != SU_OFF && (!cmp.lockout_falling_ok || force_off)) begin
            su_next = SU_OFF;
            sw_next = 1'b0;
            oplim_next = 1'b0;
            src_next = 1'b0;
        end
        if (!cmp.above_mark_reset) begin
            go_next = 1'b0;
            bsw_next = 1'b0;
            cen_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            su_reg <= SU_OFF;
            tmr_reg <= 24'h0;
            sw_reg <= 1'b0;
            oplim_reg <= 1'b0;
            go_reg <= 1'b0;
            bsw_reg <= 1'b0;
            src_reg <= 1'b0;
            cen_reg <= 1'b0;
        end else begin
            su_reg <= su_next;
            tmr_reg <= tmr_next;
            sw_reg <= sw_next;
            oplim_reg <= oplim_next;
            go_reg <= go_next;
            bsw_reg <= bsw_next;
            src_reg <= src_next;
            cen_reg <= cen_next;
        end
    end

    // ====================
    // keepalive
    ppcs_keepalive #(.T12_ON(KA_ON), .T12_PER(KA_PER)) u_ka (
        .core_clk(core_clk),
        .rst(rst),
        .enable(sw_reg && cmp.return_low_current),
        .high_type(cmp.high_type_source),
        .duty_sel(keepalive_duty_select),
        .pulse(ka_pulse)
    );

    // ====================
    // outputs
    logic [2:0] code_out;
    assign code_out = adapter_detect ? ppcs_pkg::CODE_ADAPTER : code_reg;
    assign class_drive = drive_reg;
    assign hotswap_on = sw_reg;
    assign inrush_limit_high = HIGH_POWER_VARIANT;
    assign op_limit_high = HIGH_POWER_VARIANT;
    assign limit_operational = oplim_reg;
    assign converter_go_oe = !go_reg;
    assign bias_switch_on = bsw_reg;
    assign startup_source_on = src_reg;
    assign keepalive_pulse_drive = ka_pulse;
    assign alloc_code_low = code_out[0];
    assign alloc_code_high = code_out[1];
    assign high_type_flag = code_out[2];
    assign code_enable = cen_reg || adapter_detect;
    assign power_granted = granted_reg;
endmodule

// ### sim/ppcs_pse_model.sv
// cable-side source model: comparator levels for the PD
// assumes pse maps onto cmp_raw; go held for one power-up
`timescale 1ns/1ns
module ppcs_pse_model (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [2:0] events,
    input wire logic [4:0] hold,
    output logic [5:0] pse
);
    // =====================================
    // pse: mark_reset, class, mark, rising, falling_ok, return_high
    initial begin
        pse = 6'h00;
        forever begin
            @(negedge core_clk);
            if (go) begin
                for (int i = 0; i < int'(events); i++) begin
                    pse = 6'h31;
                    repeat (hold) @(negedge core_clk);
                    pse = 6'h29;
                    repeat (hold) @(negedge core_clk);
                end
                pse = 6'h27;
                while (go) @(negedge core_clk);
                // sag below falling lockout, then full drop
                pse = 6'h21;
                repeat (hold) @(negedge core_clk);
                pse = 6'h00;
            end
        end
    end
endmodule

// ### sim/ppcs_seq_props.sv
// checker on the PD sequencer's top-level ports
// assumes one clock domain; bind at the foot
`timescale 1ns/1ns
module ppcs_seq_props #(
    parameter int unsigned INRUSH_MIN = 100,
    parameter int unsigned BIAS_HOLD = 50,
    parameter int unsigned STARTUP_TMO = 80,
    parameter bit HIGH_POWER_VARIANT = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire ppcs_pkg::ppcs_cmp_t cmp_raw,
    input wire logic thermal_limit,
    input wire logic adapter_detect,
    input wire logic detect_enable,
    input wire ppcs_pkg::ppcs_class_drive_t class_drive,
    input wire logic hotswap_on,
    input wire logic inrush_limit_high,
    input wire logic op_limit_high,
    input wire logic limit_operational,
    input wire logic converter_go_oe,
    input wire logic bias_switch_on,
    input wire logic startup_source_on,
    input wire logic alloc_code_low,
    input wire logic alloc_code_high,
    input wire logic high_type_flag,
    input wire logic code_enable
);
    int on_cnt, src_cnt, hold_cnt;
    // =====================================
    // counters, since spans are long
    always_ff @(posedge core_clk) begin
        if (rst) begin
            on_cnt <= 0;
            src_cnt <= 0;
            hold_cnt <= 0;
        end else begin
            on_cnt <= hotswap_on ? on_cnt + 1 : 0;
            src_cnt <= (startup_source_on && !bias_switch_on) ? src_cnt + 1 : 0;
            hold_cnt <= (startup_source_on && bias_switch_on) ? hold_cnt + 1 : 0;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // =====================================
    // filter takes ~6 cycles, so hold 8
    sequence s_sag;
        (!cmp_raw.lockout_falling_ok) [*8];
    endsequence
    sequence s_den;
        (!detect_enable) [*8];
    endsequence
    sequence s_block;
        (thermal_limit || adapter_detect || !detect_enable) [*8];
    endsequence
    a_limit_variant: assert property (inrush_limit_high == HIGH_POWER_VARIANT && op_limit_high == HIGH_POWER_VARIANT)
        else $error("limit level not per variant");
    a_class_block: assert property (s_block |-> !class_drive.class_en)
        else $error("class on while blocked");
    a_inrush_quiet: assert property (hotswap_on && !limit_operational |-> converter_go_oe && !startup_source_on && !bias_switch_on)
        else $error("load active in inrush");
    a_go_after_min: assert property ($fell(converter_go_oe) |-> limit_operational && on_cnt >= INRUSH_MIN - 2)
        else $error("converter go too early");
    a_bias_hold: assert property ($fell(startup_source_on) && $past(bias_switch_on) |-> hold_cnt >= BIAS_HOLD - 4)
        else $error("source off too soon");
    a_code_en: assert property (hold_cnt >= BIAS_HOLD |-> code_enable)
        else $error("codes not enabled");
    a_startup_tmo: assert property (src_cnt <= STARTUP_TMO + 2)
        else $error("startup past timeout");
    a_lockout_off: assert property (s_sag |-> !hotswap_on)
        else $error("switch on below lockout");
    a_go_kept: assert property ($fell(hotswap_on) && !converter_go_oe |=> !converter_go_oe)
        else $error("converter go pulled low");
    a_adapter_code: assert property (adapter_detect |-> code_enable && alloc_code_low && alloc_code_high && !high_type_flag)
        else $error("adapter code wrong");
    a_den_off: assert property (s_den |-> !hotswap_on)
        else $error("switch on, detect low");
endmodule

bind ppcs_sequencer ppcs_seq_props #(.INRUSH_MIN(INRUSH_MIN), .BIAS_HOLD(BIAS_HOLD),
    .STARTUP_TMO(STARTUP_TMO), .HIGH_POWER_VARIANT(HIGH_POWER_VARIANT)) u_props (.*);

// ### sim/test_poe_pd_class_startup_sequencer.sv
// self-checking bench for the PD sequencer
// assumes shortened timers; cable side comes from ppcs_pse_model
`timescale 1ns/1ns
module test_poe_pd_class_startup_sequencer;
    localparam int IM = 100, BH = 50, ST = 80, KON = 20, KPER = 60;
    int mult[4] = '{2, 3, 4, 2};
    int comparisons = 0, miscompares = 0, cycles = 0;
    logic core_clk = 1'b0, rst = 1'b1, go = 1'b0, en_d = 1'b0, ce_d = 1'b0;
    logic thermal_limit = 1'b0, adapter_detect = 1'b0, detect_enable = 1'b1, bias_undervolt_select = 1'b0;
    logic inrush_done = 1'b0, bias_in_on = 1'b0, uv_hi = 1'b0, uv_lo = 1'b0, ret_low = 1'b0, hi_type = 1'b0;
    logic [1:0] keepalive_duty_select = 2'h0;
    logic [2:0] n_ev = 3'h1;
    logic [4:0] hold;
    logic [5:0] pse;
    logic [2:0] exp_class[$], exp_code[$];
    ppcs_pkg::ppcs_class_t class_setting = ppcs_pkg::PPCS_C4;
    ppcs_pkg::ppcs_cmp_t cmp_raw;
    ppcs_pkg::ppcs_class_drive_t class_drive;
    logic hotswap_on, inrush_limit_high, op_limit_high, limit_operational, converter_go_oe, bias_switch_on;
    logic startup_source_on, keepalive_pulse_drive, alloc_code_low, alloc_code_high, high_type_flag;
    logic code_enable, power_granted;
    // no overvoltage source: cutoff tied low
    assign cmp_raw = ppcs_pkg::ppcs_cmp_t'({pse[5:3], 1'b0, pse[2:0], inrush_done, bias_in_on, uv_hi, uv_lo,
        ret_low, hi_type});
    ppcs_pse_model pse_model (.core_clk, .go, .events(n_ev), .hold, .pse);
    ppcs_sequencer #(.INRUSH_MIN(IM), .BIAS_HOLD(BH), .STARTUP_TMO(ST), .KA_ON(KON), .KA_PER(KPER)) dut (
        .core_clk, .rst, .cmp_raw, .class_setting, .thermal_limit, .adapter_detect, .detect_enable,
        .keepalive_duty_select, .bias_undervolt_select, .class_drive, .hotswap_on, .inrush_limit_high,
        .op_limit_high, .limit_operational, .converter_go_oe, .bias_switch_on, .startup_source_on,
        .keepalive_pulse_drive, .alloc_code_low, .alloc_code_high, .high_type_flag, .code_enable, .power_granted);
    always #20 core_clk = ~core_clk;
    // =====================================
    // helpers
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_time(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[FAIL] %0t span %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int cyc);
        cyc = 0;
        while (s !== v && cyc < lim) begin
            @(negedge core_clk);
            cyc++;
        end
        cmp_val(8'(s), 8'(v));
    endtask
    task automatic ka_check(input int w, input int p);
        int k, h;
        for (int i = 0; i < 2; i++) wait_lvl(keepalive_pulse_drive, 1'(i), 2 * KPER, k);
        wait_lvl(keepalive_pulse_drive, 1'b0, 2 * KPER, h);
        wait_lvl(keepalive_pulse_drive, 1'b1, 2 * KPER, k);
        cmp_time(h, w - 1, w + 1);
        if (p > 0) cmp_time(h + k, p - 1, p + 1);
    endtask
    task automatic run(input ppcs_pkg::ppcs_class_t c, input int n, input bit bias_ok);
        int k, need;
        need = (c == ppcs_pkg::PPCS_C4) ? 2 : (c <= ppcs_pkg::PPCS_C6) ? 4 : 5;
        class_setting = c;
        n_ev = 3'(n);
        hold = 5'($urandom_range(20, 10));
        hi_type = 1'($urandom_range(1, 0));
        for (int e = 0; e < n; e++) begin
            exp_class.push_back((c == ppcs_pkg::PPCS_C4 || e < 2) ? 3'h4 : 3'(int'(c) - 1));
        end
        if (bias_ok) exp_code.push_back({hi_type, n >= 5, n >= 4});
        go = 1'b1;
        wait_lvl(hotswap_on, 1'b1, 50 * n + 100, k);
        cmp_val(8'({power_granted, converter_go_oe, limit_operational, startup_source_on, bias_switch_on}),
            8'({n >= need, 4'h8}));
        repeat (20) @(negedge core_clk);
        inrush_done = 1'b1;
        wait_lvl(converter_go_oe, 1'b0, IM + 40, k);
        cmp_time(k + 20, IM, IM + 12);
        cmp_val(8'({limit_operational, startup_source_on}), 8'h03);
        if (bias_ok) begin
            bias_in_on = 1'b1;
            wait_lvl(bias_switch_on, 1'b1, 20, k);
            wait_lvl(startup_source_on, 1'b0, BH + 20, k);
            cmp_time(k, BH - 6, BH + 2);
            cmp_val(8'(code_enable), 8'h01);
            ret_low = 1'b1;
            for (int d = 0; d < 4; d++) begin
                keepalive_duty_select = 2'(d);
                adapter_detect = (d == 3);
                repeat (2 * KPER) @(negedge core_clk);
                ka_check(KON * mult[d] / (hi_type ? 20 : 2), (d == 0) ? KPER / (hi_type ? 10 : 1) : 0);
            end
            adapter_detect = 1'b0;
            ret_low = 1'b0;
            go = 1'b0;
            wait_lvl(hotswap_on, 1'b0, 12, k);
            cmp_val(8'(converter_go_oe), 8'h00);
        end else begin
            wait_lvl(bias_switch_on, 1'b1, ST + 20, k);
            cmp_time(k, ST - 4, ST + 2);
            cmp_val(8'(startup_source_on), 8'h00);
            bias_undervolt_select = 1'($urandom_range(1, 0));
            // unselected level first
            {uv_lo, uv_hi} = bias_undervolt_select ? 2'h1 : 2'h2;
            repeat (20) @(negedge core_clk);
            cmp_val(8'(startup_source_on), 8'h00);
            {uv_lo, uv_hi} = 2'h3;
            wait_lvl(startup_source_on, 1'b1, 20, k);
            detect_enable = 1'b0;
            wait_lvl(hotswap_on, 1'b0, 16, k);
            go = 1'b0;
        end
        repeat (2 * hold + 30) @(negedge core_clk);
        {inrush_done, bias_in_on, uv_lo, uv_hi, detect_enable} = 5'h01;
        cmp_val(8'(exp_class.size()), 8'h00);
    endtask
    // =====================================
    // watcher: notes popped as results appear
    always @(posedge core_clk) begin
        if (class_drive.class_en && !en_d && exp_class.size() > 0) begin
            cmp_val(8'(class_drive.class_sel), 8'(exp_class.pop_front()));
        end
        if (code_enable && !ce_d && exp_code.size() > 0) begin
            cmp_val(8'({high_type_flag, alloc_code_high, alloc_code_low}), 8'(exp_code.pop_front()));
        end
        en_d <= class_drive.class_en;
        ce_d <= code_enable;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'hB6D9583C));
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        run(ppcs_pkg::PPCS_C4, 2, 1'b1);
        run(ppcs_pkg::PPCS_C4, 5, 1'b1);
        run(ppcs_pkg::PPCS_C5, 4, 1'b1);
        run(ppcs_pkg::PPCS_C6, 3, 1'b1);
        run(ppcs_pkg::PPCS_C7, 5, 1'b1);
        run(ppcs_pkg::PPCS_C8, 4, 1'b1);
        run(ppcs_pkg::PPCS_C6, 1, 1'b0);
        exp_code.push_back(3'h3);
        adapter_detect = 1'b1;
        repeat (12) @(negedge core_clk);
        adapter_detect = 1'b0;
        repeat (4) @(negedge core_clk);
        cmp_val(8'(exp_code.size()), 8'h00);
        test_done();
    end
endmodule
